/* File: rtl/mccr_pkg.sv */
// Purpose: constants for the remote control change interpreter
// Assumes: midi bytes arrive already deserialised, one strobe per byte
// Notes  : register map reached over a plain address/strobe port
//
// Functional notes
// - level and mains CC accepted only on the configured CC channel
// - controller numbers for bus A, bus B and main levels, 0..127
// - matching level CC sets that bus volume from data 0..127
// - separate mains controllers per bus; a match toggles, data ignored
// - CC and program change act on own groups even on shared channel
// - one program change recalls same entry in every library on channel
// - act on jack messages only when enabled and source selects jack
// - every receive channel selectable 1..16
// - message source selectable between jack and host link
package mccr_pkg;
  // register index / byte offsets
  localparam logic [7:0] MCCR_REG_CTRL    = 8'h00;
  localparam logic [7:0] MCCR_REG_PCCH    = 8'h04;
  localparam logic [7:0] MCCR_REG_CCCH    = 8'h08;
  localparam logic [7:0] MCCR_REG_CCLVL   = 8'h0C;
  localparam logic [7:0] MCCR_REG_CCMUTE  = 8'h10;
  localparam logic [7:0] MCCR_REG_LEVELS  = 8'h14;
  localparam logic [7:0] MCCR_REG_ASSIGN  = 8'h18;
  localparam logic [7:0] MCCR_REG_PRESET  = 8'h1C;
  // ctrl fields
  localparam int MCCR_CTRL_EN  = 0;
  localparam int MCCR_CTRL_SRC = 1;
  // reset values: channels are stored as 0..15 (shown to users as 1..16)
  localparam logic [3:0] MCCR_CH_RESET   = 4'h0;
  localparam logic [6:0] MCCR_CC_A_LVL   = 7'h28;
  localparam logic [6:0] MCCR_CC_B_LVL   = 7'h29;
  localparam logic [6:0] MCCR_CC_M_LVL   = 7'h2A;
  localparam logic [6:0] MCCR_CC_A_MUTE  = 7'h40;
  localparam logic [6:0] MCCR_CC_B_MUTE  = 7'h42;
  localparam logic [6:0] MCCR_LVL_RESET  = 7'h00;
  // status nibbles
  localparam logic [3:0] MCCR_ST_CC = 4'hB;
  localparam logic [3:0] MCCR_ST_PC = 4'hC;
  // message kinds out of the parser
  typedef enum logic [1:0] {
    MCCR_MSG_CC = 2'h1,
    MCCR_MSG_PC = 2'h2
  } mccr_msg_t;
endpackage : mccr_pkg

/* File: rtl/mccr_sync.sv */
// Purpose: two-flop synchroniser for the jack byte strobe toggle
// Assumes: input is a level or toggle from another domain
// Notes  : first stage is read only by the second
`timescale 1ns/100ps
module mccr_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  import mccr_pkg::*;
  logic stage1;
  // two flops, no logic between
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : mccr_sync

/* File: rtl/mccr_parse.sv */
// Purpose: assemble midi channel messages from a byte stream
// Assumes: one byte per valid pulse; running status supported
// Notes  : only control change and program change are reported
`timescale 1ns/100ps
module mccr_parse (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                byte_valid,
  input  wire logic [7:0]          byte_data,
  output logic                     msg_valid,
  output mccr_pkg::mccr_msg_t      msg_kind,
  output logic [3:0]               msg_chan,
  output logic [6:0]               msg_d1,
  output logic [6:0]               msg_d2
);
  import mccr_pkg::*;
  logic [7:0] status;
  logic       have_d1;
  logic [7:0] next_status;
  logic       next_have_d1;
  logic       next_valid;
  logic [6:0] next_d1;
  logic [6:0] next_d2;
  // byte assembly; real-time bytes (F8..FF) pass without breaking status
  always_comb begin
    next_status  = status;
    next_have_d1 = have_d1;
    next_valid   = 1'b0;
    next_d1      = msg_d1;
    next_d2      = msg_d2;
    if (byte_valid) begin
      if (byte_data[7]) begin
        if (byte_data[7:3] != 5'h1F) begin
          next_status  = byte_data;
          next_have_d1 = 1'b0;
        end
      end else if (status[7:4] == MCCR_ST_PC) begin
        next_d1    = byte_data[6:0];
        next_valid = 1'b1;
      end else if (status[7:4] == MCCR_ST_CC) begin
        if (!have_d1) begin
          next_d1      = byte_data[6:0];
          next_have_d1 = 1'b1;
        end else begin
          next_d2      = byte_data[6:0];
          next_have_d1 = 1'b0;
          next_valid   = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status    <= 8'h00;
      have_d1   <= 1'b0;
      msg_valid <= 1'b0;
      msg_d1    <= 7'h00;
      msg_d2    <= 7'h00;
    end else begin
      status    <= next_status;
      have_d1   <= next_have_d1;
      msg_valid <= next_valid;
      msg_d1    <= next_d1;
      msg_d2    <= next_d2;
    end
  end
  assign msg_chan = status[3:0];
  assign msg_kind = (status[7:4] == MCCR_ST_PC) ? MCCR_MSG_PC : MCCR_MSG_CC;
endmodule : mccr_parse

/* File: rtl/mccr_top.sv */
// Purpose: remote control interpreter for bus levels, mains and presets
// Assumes: jack bytes come from another domain with a toggle strobe;
//          host link bytes are on this clock
// Notes  : registers on a plain port, read data one cycle after strobe
//        : a disabled or deselected stream is dropped whole, not queued
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module mccr_top (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       jack_byte_toggle,
  input  wire logic [7:0] jack_byte_data,
  input  wire logic       host_byte_valid,
  input  wire logic [7:0] host_byte_data,
  input  wire logic [7:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [31:0]     reg_rdata,
  output logic [6:0]      effects_bus_a_level,
  output logic [6:0]      effects_bus_b_level,
  output logic [6:0]      main_level,
  output logic            effects_bus_a_to_mains,
  output logic            effects_bus_b_to_mains,
  output logic            scene_recall,
  output logic            effects_bus_a_recall,
  output logic            effects_bus_b_recall,
  output logic [6:0]      recall_number
);
  import mccr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // configuration state
  logic       remote_control_enable;
  logic       remote_message_source;  // 0 jack, 1 host link
  // receive channels, stored 0..15 for channels 1..16
  logic [3:0] scene_ch;
  logic [3:0] fxa_ch;
  logic [3:0] fxb_ch;
  logic [3:0] cc_ch;
  // controller numbers for the three levels and two mains toggles
  logic [6:0] cc_a_lvl;
  logic [6:0] cc_b_lvl;
  logic [6:0] cc_m_lvl;
  logic [6:0] cc_a_mute;
  logic [6:0] cc_b_mute;
  // next values of the configuration
  logic       next_enable;
  logic       next_source;
  logic [3:0] next_scene_ch;
  logic [3:0] next_fxa_ch;
  logic [3:0] next_fxb_ch;
  logic [3:0] next_cc_ch;
  logic [6:0] next_cc_a_lvl;
  logic [6:0] next_cc_b_lvl;
  logic [6:0] next_cc_m_lvl;
  logic [6:0] next_cc_a_mute;
  logic [6:0] next_cc_b_mute;

  ////////////////////////////////////////////////////////////////////////
  // jack byte path: data held stable while the toggle crosses
  // the data bus is sampled twice as well; the sender holds it three
  // cycles before the toggle and four after, so the second stage is settled
  // by the time the delayed toggle edge marks it valid
  logic       jack_tog_s;
  logic       jack_tog_d;
  logic [7:0] jack_data_s1;
  logic [7:0] jack_data_s2;
  logic       jack_valid;
  mccr_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (jack_byte_toggle),
    .dout    (jack_tog_s)
  );
  // toggle and data flops reset together, so no false byte after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      jack_data_s1 <= 8'h00;
      jack_data_s2 <= 8'h00;
      jack_tog_d   <= 1'b0;
    end else begin
      jack_data_s1 <= jack_byte_data;
      jack_data_s2 <= jack_data_s1;
      jack_tog_d   <= jack_tog_s;
    end
  end
  // one valid cycle per toggle edge, in either direction
  assign jack_valid = jack_tog_s ^ jack_tog_d;

  // source selects jack or host link
  // the unselected stream is dropped before parsing so no half message mixes
  logic       src_valid;
  logic [7:0] src_data;
  always_comb begin
    src_valid = remote_message_source ? host_byte_valid : jack_valid;
    src_data  = remote_message_source ? host_byte_data : jack_data_s2;
  end

  logic       msg_valid;
  mccr_msg_t  msg_kind;
  logic [3:0] msg_chan;
  // parser output: one pulse per complete control or program change
  logic [6:0] msg_d1;
  logic [6:0] msg_d2;
  // one parser for both sources; a source switch mid-message may leave
  // a partial status behind, so switch only between messages
  mccr_parse u_parse (
    .clk        (clk),
    .reset_n    (reset_n),
    .byte_valid (src_valid),
    .byte_data  (src_data),
    .msg_valid  (msg_valid),
    .msg_kind   (msg_kind),
    .msg_chan   (msg_chan),
    .msg_d1     (msg_d1),
    .msg_d2     (msg_d2)
  );

  ////////////////////////////////////////////////////////////////////////
  // controller match helper
  // every compare is one exact 7-bit match with no masking, so all
  // 128 controller numbers stay usable
  function automatic logic cc_hit(input logic [6:0] num,
                                  input logic [6:0] cfg);
    cc_hit = (num == cfg);
  endfunction : cc_hit

  // qualified message strobes
  logic       act;
  logic       is_cc;
  logic       is_pc;
  // next output values
  logic [6:0] next_a_lvl;
  logic [6:0] next_b_lvl;
  logic [6:0] next_m_lvl;
  logic [6:0] next_recall_num;
  logic       next_a_mains;
  logic       next_b_mains;
  logic       next_scene;
  logic       next_fxa;
  logic       next_fxb;
  // message interpretation
  always_comb begin
    act   = msg_valid && remote_control_enable;
    is_cc = act && (msg_kind == MCCR_MSG_CC);
    is_pc = act && (msg_kind == MCCR_MSG_PC);
    next_a_lvl      = effects_bus_a_level;
    next_b_lvl      = effects_bus_b_level;
    next_m_lvl      = main_level;
    next_a_mains    = effects_bus_a_to_mains;
    next_b_mains    = effects_bus_b_to_mains;
    next_recall_num = recall_number;
    next_scene      = 1'b0;
    next_fxa        = 1'b0;
    next_fxb        = 1'b0;
    // channel filter, others ignored
    // a shared number drives every parameter it matches, as users expect
    if (is_cc && msg_chan == cc_ch) begin
      if (cc_hit(msg_d1, cc_a_lvl)) next_a_lvl = msg_d2;
      if (cc_hit(msg_d1, cc_b_lvl)) next_b_lvl = msg_d2;
      if (cc_hit(msg_d1, cc_m_lvl)) next_m_lvl = msg_d2;
      if (cc_hit(msg_d1, cc_a_mute)) next_a_mains = !effects_bus_a_to_mains;
      if (cc_hit(msg_d1, cc_b_mute)) next_b_mains = !effects_bus_b_to_mains;
    end
    if (is_pc) begin
      next_scene = (msg_chan == scene_ch);
      next_fxa   = (msg_chan == fxa_ch);
      next_fxb   = (msg_chan == fxb_ch);
      if (next_scene || next_fxa || next_fxb) next_recall_num = msg_d1;
    end
  end

  // every output comes from a flop here; recall pulses last one cycle,
  // the recall number stands until the next recall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      effects_bus_a_level    <= MCCR_LVL_RESET;
      effects_bus_b_level    <= MCCR_LVL_RESET;
      main_level             <= MCCR_LVL_RESET;
      effects_bus_a_to_mains <= 1'b1;
      effects_bus_b_to_mains <= 1'b1;
      recall_number          <= 7'h00;
      scene_recall           <= 1'b0;
      effects_bus_a_recall   <= 1'b0;
      effects_bus_b_recall   <= 1'b0;
    end else begin
      effects_bus_a_level    <= next_a_lvl;
      effects_bus_b_level    <= next_b_lvl;
      main_level             <= next_m_lvl;
      effects_bus_a_to_mains <= next_a_mains;
      effects_bus_b_to_mains <= next_b_mains;
      recall_number          <= next_recall_num;
      scene_recall           <= next_scene;
      effects_bus_a_recall   <= next_fxa;
      effects_bus_b_recall   <= next_fxb;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes
  // unmapped and read-only offsets fall to default and change nothing
  always_comb begin
    next_enable    = remote_control_enable;
    next_source    = remote_message_source;
    next_scene_ch  = scene_ch;
    next_fxa_ch    = fxa_ch;
    next_fxb_ch    = fxb_ch;
    next_cc_ch     = cc_ch;
    next_cc_a_lvl  = cc_a_lvl;
    next_cc_b_lvl  = cc_b_lvl;
    next_cc_m_lvl  = cc_m_lvl;
    next_cc_a_mute = cc_a_mute;
    next_cc_b_mute = cc_b_mute;
    if (reg_write) begin
      unique case (reg_addr)
        MCCR_REG_CTRL: begin
          next_enable = reg_wdata[MCCR_CTRL_EN];
          next_source = reg_wdata[MCCR_CTRL_SRC];
        end
        MCCR_REG_PCCH: begin
          next_scene_ch = reg_wdata[3:0];
          next_fxa_ch   = reg_wdata[11:8];
          next_fxb_ch   = reg_wdata[19:16];
        end
        MCCR_REG_CCCH: next_cc_ch = reg_wdata[3:0];
        MCCR_REG_CCLVL: begin
          next_cc_a_lvl = reg_wdata[6:0];
          next_cc_b_lvl = reg_wdata[14:8];
          next_cc_m_lvl = reg_wdata[22:16];
        end
        MCCR_REG_CCMUTE: begin
          next_cc_a_mute = reg_wdata[6:0];
          next_cc_b_mute = reg_wdata[14:8];
        end
        default: ;
      endcase
    end
  end

  // configuration flops; reset gives a usable map with remote control off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remote_control_enable <= 1'b0;
      remote_message_source <= 1'b0;
      scene_ch  <= MCCR_CH_RESET;
      fxa_ch    <= MCCR_CH_RESET;
      fxb_ch    <= MCCR_CH_RESET;
      cc_ch     <= MCCR_CH_RESET;
      cc_a_lvl  <= MCCR_CC_A_LVL;
      cc_b_lvl  <= MCCR_CC_B_LVL;
      cc_m_lvl  <= MCCR_CC_M_LVL;
      cc_a_mute <= MCCR_CC_A_MUTE;
      cc_b_mute <= MCCR_CC_B_MUTE;
    end else begin
      remote_control_enable <= next_enable;
      remote_message_source <= next_source;
      scene_ch  <= next_scene_ch;
      fxa_ch    <= next_fxa_ch;
      fxb_ch    <= next_fxb_ch;
      cc_ch     <= next_cc_ch;
      cc_a_lvl  <= next_cc_a_lvl;
      cc_b_lvl  <= next_cc_b_lvl;
      cc_m_lvl  <= next_cc_m_lvl;
      cc_a_mute <= next_cc_a_mute;
      cc_b_mute <= next_cc_b_mute;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads; unmapped reads return zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read) begin
      unique case (reg_addr)
        MCCR_REG_CTRL:   next_rdata = {30'h0, remote_message_source,
                                       remote_control_enable};
        MCCR_REG_PCCH:   next_rdata = {12'h0, fxb_ch, 4'h0, fxa_ch,
                                       4'h0, scene_ch};
        MCCR_REG_CCCH:   next_rdata = {28'h0, cc_ch};
        MCCR_REG_CCLVL:  next_rdata = {9'h0, cc_m_lvl, 1'b0, cc_b_lvl,
                                       1'b0, cc_a_lvl};
        MCCR_REG_CCMUTE: next_rdata = {17'h0, cc_b_mute, 1'b0, cc_a_mute};
        MCCR_REG_LEVELS: next_rdata = {9'h0, main_level, 1'b0,
                                       effects_bus_b_level, 1'b0,
                                       effects_bus_a_level};
        MCCR_REG_ASSIGN: next_rdata = {30'h0, effects_bus_b_to_mains,
                                       effects_bus_a_to_mains};
        MCCR_REG_PRESET: next_rdata = {25'h0, recall_number};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
  end
  // read data stands for one cycle only, then falls back to zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) reg_rdata <= 32'h0000_0000;
    else          reg_rdata <= next_rdata;
  end
endmodule : mccr_top

/* File: testbench/mccr_monitor.sv */
// Purpose: port-level checks for the remote control interpreter
// Assumes: one clock, async active-low reset
// Notes  : byte activity age stands in for the hidden configuration
`timescale 1ns/100ps
module mccr_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        jack_byte_toggle,
  input wire logic [7:0]  jack_byte_data,
  input wire logic        host_byte_valid,
  input wire logic [7:0]  host_byte_data,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [6:0]  effects_bus_a_level,
  input wire logic [6:0]  effects_bus_b_level,
  input wire logic [6:0]  main_level,
  input wire logic        effects_bus_a_to_mains,
  input wire logic        effects_bus_b_to_mains,
  input wire logic        scene_recall,
  input wire logic        effects_bus_a_recall,
  input wire logic        effects_bus_b_recall,
  input wire logic [6:0]  recall_number
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] since;
  logic [3:0] next_since;
  logic       tog_q;
  ////////////////////////////////////////////////////////////////////////
  // cycles since the last byte; saturates so it never wraps to "recent"
  always_comb begin
    next_since = since;
    if (host_byte_valid || (jack_byte_toggle != tog_q))
      next_since = 4'h0;
    else if (since != 4'hF)
      next_since = since + 4'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since <= 4'hF;
      tog_q <= 1'b0;
    end else begin
      since <= next_since;
      tog_q <= jack_byte_toggle;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_recall;
    scene_recall || effects_bus_a_recall || effects_bus_b_recall;
  endsequence
  sequence s_lvl_move;
    !$stable({effects_bus_a_level, effects_bus_b_level, main_level});
  endsequence
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  unmapped_read_a: assert property (reg_read && reg_addr > 8'h1C
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  recall_pulse_a: assert property (s_recall |=> !(scene_recall
    || effects_bus_a_recall || effects_bus_b_recall))
    else $error("recall pulse longer than one cycle");
  recall_kind_a: assert property (s_recall |-> $stable({effects_bus_a_level,
    effects_bus_b_level, main_level, effects_bus_a_to_mains,
    effects_bus_b_to_mains})) else $error("program change moved levels");
  number_cause_a: assert property ($changed(recall_number) |-> s_recall)
    else $error("recall number changed without recall");
  level_cause_a: assert property (s_lvl_move |-> since <= 4'd12)
    else $error("level changed without a message");
  mains_cause_a: assert property (!$stable({effects_bus_a_to_mains,
    effects_bus_b_to_mains}) |-> since <= 4'd12)
    else $error("mains toggled without a message");
  mains_single_a: assert property ($changed(effects_bus_a_to_mains)
    |-> $stable(effects_bus_b_to_mains)) else $error("both mains toggled");
  reset_value_a: assert property ($rose(reset_n) |-> main_level == 7'h00
    && effects_bus_a_level == 7'h00 && effects_bus_b_level == 7'h00
    && effects_bus_a_to_mains && effects_bus_b_to_mains)
    else $error("outputs not at reset values");
endmodule : mccr_monitor
bind mccr_top mccr_monitor u_mon (.clk(clk), .reset_n(reset_n),
  .jack_byte_toggle(jack_byte_toggle), .jack_byte_data(jack_byte_data),
  .host_byte_valid(host_byte_valid), .host_byte_data(host_byte_data),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .effects_bus_a_level(effects_bus_a_level),
  .effects_bus_b_level(effects_bus_b_level), .main_level(main_level),
  .effects_bus_a_to_mains(effects_bus_a_to_mains),
  .effects_bus_b_to_mains(effects_bus_b_to_mains),
  .scene_recall(scene_recall), .effects_bus_a_recall(effects_bus_a_recall),
  .effects_bus_b_recall(effects_bus_b_recall),
  .recall_number(recall_number));

/* File: testbench/mccr_midi_src.sv */
// Purpose: jack-side controller model sending midi bytes
// Assumes: byte held 3 clk before and 4 clk after each toggle
// Notes  : a released byte shows its inverse, never the old value
`timescale 1ns/100ps
module mccr_midi_src (
  input  wire logic  clk,
  output logic       jack_byte_toggle,
  output logic [7:0] jack_byte_data
);
  initial begin
    jack_byte_toggle = 1'b0;
    jack_byte_data   = 8'hFF;
  end
  ////////////////////////////////////////////////////////////////////////
  // distinct numbers kept by the caller's setup
  // one byte: present, hold, toggle, hold, then scramble
  task automatic send(input logic [7:0] b);
    jack_byte_data <= b;
    repeat (3) @(posedge clk);
    jack_byte_toggle <= ~jack_byte_toggle;
    repeat (4) @(posedge clk);
    jack_byte_data <= ~b; // stale byte must not pass for a fresh one
    @(posedge clk);
  endtask : send
endmodule : mccr_midi_src

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the remote control interpreter
// Assumes: expected results queued by the driver, matched by a watcher
// Notes  : ignored messages are checked by the absence of any output move
`timescale 1ns/100ps
module tb;
  import mccr_pkg::*;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s expected %h seen %h", nm, e, g); end end
  logic clk = 0, reset_n = 0, host_byte_valid = 0, reg_write = 0;
  logic reg_read = 0, rd_pend = 0, jack_byte_toggle;
  logic [7:0] host_byte_data = 8'h00, reg_addr = 8'h00, jack_byte_data;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, re;
  logic [6:0] lva, lvb, lvm, recall_number, e_lv[3], e_num = 7'h00;
  logic am, bm, sr, ar, br;
  logic [1:0] e_mn = 2'b11;
  logic [32:0] snap, prev, e, out_q[$];
  logic [31:0] rd_q[$];
  int mismatches = 0, comparisons = 0, seed = 73;
  mccr_top u_dut (.clk(clk), .reset_n(reset_n),
    .jack_byte_toggle(jack_byte_toggle), .jack_byte_data(jack_byte_data),
    .host_byte_valid(host_byte_valid), .host_byte_data(host_byte_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .effects_bus_a_level(lva),
    .effects_bus_b_level(lvb), .main_level(lvm), .effects_bus_a_to_mains(am),
    .effects_bus_b_to_mains(bm), .scene_recall(sr),
    .effects_bus_a_recall(ar), .effects_bus_b_recall(br),
    .recall_number(recall_number));
  mccr_midi_src u_src (.clk(clk), .jack_byte_toggle(jack_byte_toggle),
    .jack_byte_data(jack_byte_data));
  assign snap = {lva, lvb, lvm, am, bm, sr, ar, br, recall_number};
  ////////////////////////////////////////////////////////////////////////
  initial forever #2 clk = ~clk;
  // watcher: any move of levels or mains, or a pulse, takes one note
  always @(posedge clk) begin
    if (rd_pend) begin
      re = rd_q.size() ? rd_q.pop_front() : 'x;
      `CHK("reg_rdata", re, reg_rdata)
    end
    rd_pend <= reg_read;
    if (reset_n && (snap[32:10] !== prev[32:10] || |snap[9:7])) begin
      e = out_q.size() ? out_q.pop_front() : 'x;
      `CHK("outputs", e, snap)
    end
    prev <= snap;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clk) reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rd_q.push_back(x); reg_addr <= a; reg_read <= 1'b1;
    @(posedge clk) reg_read <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic note(input logic [2:0] p);
    out_q.push_back({e_lv[0], e_lv[1], e_lv[2], e_mn, p, e_num});
  endtask : note
  // message of n bytes over jack or host, then room for its answer
  task automatic msg(input logic [7:0] s, d1, d2, input int n, input bit j);
    if (j) begin
      u_src.send(s); u_src.send(d1);
      if (n == 3) u_src.send(d2);
    end else begin
      host_byte_valid <= 1'b1; host_byte_data <= s; @(posedge clk);
      host_byte_data <= d1; @(posedge clk);
      if (n == 3) begin host_byte_data <= d2; @(posedge clk); end
      host_byte_valid <= 1'b0;
    end
    repeat (20) @(posedge clk);
    `CHK("missing results", 0, out_q.size())
  endtask : msg
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #80000;
    mismatches++;
    conclude();
  end
  initial begin
    e_lv = '{7'h00, 7'h00, 7'h00};
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(MCCR_REG_CTRL, 0); rd(MCCR_REG_CCLVL, 32'h2A2928);
    rd(MCCR_REG_CCMUTE, 32'h4240); rd(MCCR_REG_ASSIGN, 32'h3);
    rd(MCCR_REG_LEVELS, 0); rd(8'h40, 0);
    msg(8'hB0, 8'h28, 8'h11, 3, 1);
    $display("test defaults done");
    wr(MCCR_REG_PCCH, 32'h20100); wr(MCCR_REG_CCCH, 32'h3); wr(0, 32'h1);
    for (int i = 0; i < 3; i++) begin
      e_lv[i] = 7'($random(seed)) | 7'h01;
      note(3'b000); msg(8'hB3, 8'h28 + 8'(i), {1'b0, e_lv[i]}, 3, 1);
    end
    msg(8'hB2, 8'h28, 8'h55, 3, 1); msg(8'hB3, 8'h30, 8'h55, 3, 1);
    msg(8'hC3, 8'h28, 8'h00, 2, 1);
    for (int v = 0; v < 4; v++) begin
      e_mn[v[1] ? 0 : 1] ^= 1'b1; note(3'b000);
      msg(8'hB3, v[1] ? 8'h42 : 8'h40, v[0] ? 8'h7F : 8'h00, 3, 1);
    end
    $display("test jack done");
    wr(MCCR_REG_CTRL, 32'h3); msg(8'hB3, 8'h2A, 8'h7F, 3, 1);
    for (int k = 0; k < 3; k++) begin
      e_num = 7'($random(seed)); note(3'b100 >> k);
      msg(8'hC0 | 8'(k), {1'b0, e_num}, 8'h00, 2, 0);
    end
    wr(MCCR_REG_CCLVL, 32'h00057F00); rd(MCCR_REG_CCLVL, 32'h00057F00);
    e_lv[0] = ~e_lv[0]; note(3'b000); msg(8'hB3, 0, {1'b0, e_lv[0]}, 3, 0);
    e_lv[1] = ~e_lv[1]; note(3'b000); msg(8'hB3, 127, {1'b0, e_lv[1]}, 3, 0);
    for (int c = 0; c < 16; c++) begin
      wr(MCCR_REG_CCCH, c); wr(MCCR_REG_PCCH, 32'h10101 * c);
      e_lv[2] = ~e_lv[2]; note(3'b000);
      msg({4'hB, 4'(c)}, 8'h05, {1'b0, e_lv[2]}, 3, 0);
      e_num = 7'($random(seed)); note(3'b111);
      msg({4'hC, 4'(c)}, {1'b0, e_num}, 8'h00, 2, 0);
    end
    rd(MCCR_REG_LEVELS, {9'h0, e_lv[2], 1'b0, e_lv[1], 1'b0, e_lv[0]});
    rd(MCCR_REG_ASSIGN, {30'h0, e_mn[0], e_mn[1]});
    rd(MCCR_REG_PRESET, {25'h0, e_num});
    $display("test host done");
    conclude();
  end
endmodule : tb
